/* File: include/dtx_map.svh */
// Constants for the data-transfer execution unit.
`ifndef DTX_MAP_SVH
`define DTX_MAP_SVH
`define DTX_IO_DATA_OFS 16'h0020
`define DTX_CYC_LOAD 2'h2
`define DTX_CYC_STORE 2'h2
`define DTX_CYC_PMEM 2'h3
`define DTX_CYC_STACK 2'h2
`define DTX_ONE 16'h0001
`define DTX_R0 5'h00
`define DTX_RESET_SP 16'h00df
`endif

/* File: include/dtx_pkg.sv */
// Types for the data-transfer execution unit.
package dtx_pkg;
    typedef enum logic [4:0] {
        DTX_OP_NOP = 5'h00,
        DTX_OP_LOAD_ABS = 5'h01,
        DTX_OP_WR_PTR = 5'h02,
        DTX_OP_WR_PTR_INC = 5'h03,
        DTX_OP_WR_PTR_DEC = 5'h04,
        DTX_OP_WR_OFS = 5'h05,
        DTX_OP_WR_ABS = 5'h06,
        DTX_OP_PMEM = 5'h07,
        DTX_OP_PMEM_INC = 5'h08,
        DTX_OP_PUSH = 5'h09,
        DTX_OP_POP = 5'h0a,
        DTX_OP_IN = 5'h0b,
        DTX_OP_OUT = 5'h0c,
        DTX_OP_SLEEP = 5'h0d,
        DTX_OP_KICK = 5'h0e,
        DTX_OP_BREAK = 5'h0f,
        DTX_OP_LOAD_IO = 5'h10
    } dtx_op_t;
    typedef enum logic [1:0] {
        DTX_PTR_X = 2'h0,
        DTX_PTR_Y = 2'h1,
        DTX_PTR_Z = 2'h2
    } dtx_ptr_t;
    typedef struct packed {
        dtx_op_t op;
        dtx_ptr_t ptr;
        logic [4:0] reg_idx;
        logic [15:0] addr;
        logic [5:0] disp;
        logic [5:0] port;
        logic use_r0;
    } dtx_cmd_t;
    typedef enum logic [3:0] {
        DTX_ST_IDLE = 4'h1,
        DTX_ST_MEM = 4'h2,
        DTX_ST_WAIT = 4'h4,
        DTX_ST_DONE = 4'h8
    } dtx_state_t;
    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dtx_bus_t;
    typedef struct packed {
        dtx_state_t st;
        dtx_cmd_t cmd;
        logic [1:0] cnt;
        logic [15:0] ea;
        logic busy;
        logic done;
        dtx_bus_t dmem;
        logic pmem_re;
        logic [15:0] pmem_addr;
        logic io_we;
        logic io_re;
        logic [5:0] io_addr;
        logic [7:0] io_wdata;
        logic rf_we;
        logic [4:0] rf_idx;
        logic [7:0] rf_wdata;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
        logic [15:0] sp;
        logic sleep;
        logic kick;
        logic brk;
        logic [7:0] src;
    } dtx_state_s_t;
endpackage

/* File: design/dtx_ptr_file.sv */
// Pointer register bank X, Y, Z with registered read data.
module dtx_ptr_file
    import dtx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic we_in,
    input wire dtx_ptr_t sel_in,
    input wire logic [15:0] wdata_in,
    input wire dtx_ptr_t rsel_in,
    output logic [15:0] rdata_out
);
    logic [15:0] mem_r [3];
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_ptr
            always_ff @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    mem_r[g] <= 16'h0000;
                else if (we_in && sel_in == dtx_ptr_t'(g))
                    mem_r[g] <= wdata_in;
            end
        end
    endgenerate
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_out <= 16'h0000;
        else if (rsel_in == DTX_PTR_Y)
            rdata_out <= mem_r[1];
        else if (rsel_in == DTX_PTR_Z)
            rdata_out <= mem_r[2];
        else
            rdata_out <= mem_r[0];
    end
endmodule

/* File: design/dtx_exec.sv */
// Execution unit for data-transfer and core-control instructions.
`include "dtx_map.svh"
// Contract
// - Absolute load copies data byte at instruction address to register, two cycles.
// - Post-increment pointer store writes at pointer, then adds one; two cycles.
// - Pre-decrement pointer store subtracts one first, then writes; two cycles.
// - Offset store writes at Y or Z plus q, pointer kept; two cycles.
// - Absolute store writes register at instruction address in two cycles.
// - Program fetch reads byte at Z into register or R0; three cycles.
// - Push stores register at stack location in two cycles.
// - Pop loads register from stack in two cycles.
// - Break only signals debug, single cycle, no flags.
// - Data-space address of I/O register is port address plus 0x20.
module dtx_exec
    import dtx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire dtx_cmd_t cmd_in,
    input wire logic [7:0] rf_rdata_in,
    input wire logic [7:0] dmem_rdata_in,
    input wire logic [7:0] pmem_rdata_in,
    input wire logic [7:0] io_rdata_in,
    output logic [4:0] rf_ridx_out,
    output logic busy_out,
    output logic done_out,
    output dtx_bus_t dmem_out,
    output logic pmem_re_out,
    output logic [15:0] pmem_addr_out,
    output logic io_we_out,
    output logic io_re_out,
    output logic [5:0] io_addr_out,
    output logic [7:0] io_wdata_out,
    output logic rf_we_out,
    output logic [4:0] rf_widx_out,
    output logic [7:0] rf_wdata_out,
    output logic [15:0] z_out,
    output logic [15:0] sp_out,
    output logic sleep_out,
    output logic kick_out,
    output logic brk_out
);
    dtx_state_s_t s_r;
    dtx_state_s_t s_nxt;
    logic [15:0] ptr_val;
    logic ptr_we;
    dtx_ptr_t ptr_sel;
    logic [15:0] ptr_wdata;
    logic [15:0] base;

    // The pointer bank is mirrored in the state so the address is ready in the issue cycle.
    dtx_ptr_file u_ptr (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .we_in(ptr_we),
        .sel_in(ptr_sel),
        .wdata_in(ptr_wdata),
        .rsel_in(cmd_in.ptr),
        .rdata_out(ptr_val)
    );

    always_comb
    begin
        s_nxt = s_r;
        ptr_we = 1'b0;
        ptr_sel = cmd_in.ptr;
        ptr_wdata = 16'h0000;
        base = (cmd_in.ptr == DTX_PTR_Y) ? s_r.y : (cmd_in.ptr == DTX_PTR_Z) ? s_r.z : s_r.x;
        s_nxt.done = 1'b0;
        s_nxt.dmem = '0;
        s_nxt.pmem_re = 1'b0;
        s_nxt.io_we = 1'b0;
        s_nxt.io_re = 1'b0;
        s_nxt.rf_we = 1'b0;
        s_nxt.sleep = 1'b0;
        s_nxt.kick = 1'b0;
        s_nxt.brk = 1'b0;
        case (s_r.st)
            DTX_ST_IDLE:
            begin
                if (start_in)
                begin
                    s_nxt.cmd = cmd_in;
                    s_nxt.src = rf_rdata_in;
                    s_nxt.busy = 1'b1;
                    s_nxt.st = DTX_ST_MEM;
                    s_nxt.cnt = `DTX_CYC_STORE;
                    case (cmd_in.op)
                        DTX_OP_LOAD_ABS, DTX_OP_WR_ABS:
                            s_nxt.ea = cmd_in.addr;
                        DTX_OP_LOAD_IO:
                            s_nxt.ea = {10'h000, cmd_in.port} + `DTX_IO_DATA_OFS;
                        DTX_OP_WR_PTR, DTX_OP_WR_PTR_INC:
                            s_nxt.ea = base;
                        DTX_OP_WR_PTR_DEC:
                            s_nxt.ea = base - `DTX_ONE;
                        DTX_OP_WR_OFS:
                            s_nxt.ea = base + {10'h000, cmd_in.disp};
                        DTX_OP_PMEM, DTX_OP_PMEM_INC:
                        begin
                            s_nxt.ea = s_r.z;
                            s_nxt.cnt = `DTX_CYC_PMEM;
                            s_nxt.pmem_re = 1'b1;
                            s_nxt.pmem_addr = s_r.z;
                            s_nxt.st = DTX_ST_WAIT;
                            if (cmd_in.use_r0)
                                s_nxt.cmd.reg_idx = `DTX_R0;
                        end
                        DTX_OP_PUSH:
                            s_nxt.ea = s_r.sp;
                        DTX_OP_POP:
                        begin
                            s_nxt.ea = s_r.sp + `DTX_ONE;
                            s_nxt.sp = s_r.sp + `DTX_ONE;
                        end
                        default:
                        begin
                            // Single-cycle operations finish in the issue cycle.
                            s_nxt.st = DTX_ST_IDLE;
                            s_nxt.busy = 1'b0;
                            s_nxt.done = 1'b1;
                            s_nxt.io_addr = cmd_in.port;
                            s_nxt.io_wdata = rf_rdata_in;
                            s_nxt.io_we = (cmd_in.op == DTX_OP_OUT);
                            s_nxt.io_re = (cmd_in.op == DTX_OP_IN);
                            s_nxt.sleep = (cmd_in.op == DTX_OP_SLEEP);
                            s_nxt.kick = (cmd_in.op == DTX_OP_KICK);
                            s_nxt.brk = (cmd_in.op == DTX_OP_BREAK);
                            s_nxt.rf_idx = cmd_in.reg_idx;
                        end
                    endcase
                    // Reads strobe at issue so the byte is written back in the second cycle.
                    if (cmd_in.op == DTX_OP_LOAD_ABS || cmd_in.op == DTX_OP_LOAD_IO ||
                        cmd_in.op == DTX_OP_POP)
                    begin
                        s_nxt.dmem.re = 1'b1;
                        s_nxt.dmem.addr = s_nxt.ea;
                        s_nxt.st = DTX_ST_DONE;
                    end
                end
            end
            DTX_ST_MEM:
            begin
                // Only stores and push reach this state; reads were strobed at issue.
                case (s_r.cmd.op)
                    default:
                    begin
                        s_nxt.dmem.we = 1'b1;
                        s_nxt.dmem.addr = s_r.ea;
                        s_nxt.dmem.wdata = s_r.src;
                        s_nxt.st = DTX_ST_IDLE;
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                        if (s_r.cmd.op == DTX_OP_WR_PTR_INC)
                            ptr_wdata = s_r.ea + `DTX_ONE;
                        else
                            ptr_wdata = s_r.ea;
                        ptr_we = (s_r.cmd.op == DTX_OP_WR_PTR_INC) ||
                                 (s_r.cmd.op == DTX_OP_WR_PTR_DEC);
                        ptr_sel = s_r.cmd.ptr;
                        if (ptr_we && s_r.cmd.ptr == DTX_PTR_X)
                            s_nxt.x = ptr_wdata;
                        if (ptr_we && s_r.cmd.ptr == DTX_PTR_Y)
                            s_nxt.y = ptr_wdata;
                        if (ptr_we && s_r.cmd.ptr == DTX_PTR_Z)
                            s_nxt.z = ptr_wdata;
                        if (s_r.cmd.op == DTX_OP_PUSH)
                            s_nxt.sp = s_r.sp - `DTX_ONE;
                    end
                endcase
            end
            DTX_ST_WAIT:
                s_nxt.st = DTX_ST_DONE;
            DTX_ST_DONE:
            begin
                s_nxt.st = DTX_ST_IDLE;
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.rf_we = 1'b1;
                s_nxt.rf_idx = s_r.cmd.reg_idx;
                if (s_r.cmd.op == DTX_OP_PMEM || s_r.cmd.op == DTX_OP_PMEM_INC)
                    s_nxt.rf_wdata = pmem_rdata_in;
                else
                    s_nxt.rf_wdata = dmem_rdata_in;
                if (s_r.cmd.op == DTX_OP_PMEM_INC)
                begin
                    s_nxt.z = s_r.z + `DTX_ONE;
                    ptr_we = 1'b1;
                    ptr_sel = DTX_PTR_Z;
                    ptr_wdata = s_r.z + `DTX_ONE;
                end
            end
            default:
                s_nxt.st = DTX_ST_IDLE;
        endcase
        if (s_r.io_re)
        begin
            // Port reads land one cycle after the strobe.
            s_nxt.rf_we = 1'b1;
            s_nxt.rf_wdata = io_rdata_in;
            // The port read's own index, since a start in its done cycle may move rf_idx.
            s_nxt.rf_idx = s_r.cmd.reg_idx;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s_r <= '0;
            s_r.st <= DTX_ST_IDLE;
            s_r.sp <= `DTX_RESET_SP;
        end
        else
            s_r <= s_nxt;
    end

    assign rf_ridx_out = cmd_in.reg_idx;
    assign busy_out = s_r.busy;
    assign done_out = s_r.done;
    assign dmem_out = s_r.dmem;
    assign pmem_re_out = s_r.pmem_re;
    assign pmem_addr_out = s_r.pmem_addr;
    assign io_we_out = s_r.io_we;
    assign io_re_out = s_r.io_re;
    assign io_addr_out = s_r.io_addr;
    assign io_wdata_out = s_r.io_wdata;
    assign rf_we_out = s_r.rf_we;
    assign rf_widx_out = s_r.rf_idx;
    assign rf_wdata_out = s_r.rf_wdata;
    assign z_out = s_r.z;
    assign sp_out = s_r.sp;
    assign sleep_out = s_r.sleep;
    assign kick_out = s_r.kick;
    assign brk_out = s_r.brk;

    store_two_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_WR_ABS) |-> ##2 (dmem_out.we &&
        dmem_out.addr == $past(cmd_in.addr, 2) && done_out))
        else $error("absolute store not issued at cycle two");
    load_two_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_LOAD_ABS) |-> ##1 dmem_out.re ##1
        (rf_we_out && done_out))
        else $error("absolute load timing wrong");
    post_inc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_WR_PTR_INC && cmd_in.ptr == DTX_PTR_Z)
        |-> ##2 (dmem_out.we && z_out == dmem_out.addr + 16'h0001))
        else $error("post increment wrong");
    pre_dec_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_WR_PTR_DEC && cmd_in.ptr == DTX_PTR_Z)
        |-> ##2 (dmem_out.we && z_out == dmem_out.addr && z_out == $past(z_out, 2) - 16'h0001))
        else $error("pre decrement wrong");
    offset_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_WR_OFS) |-> ##2 (dmem_out.we &&
        $stable(z_out)))
        else $error("offset store moved pointer");
    pmem_three_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_PMEM) |-> ##1 pmem_re_out ##2
        (rf_we_out && done_out))
        else $error("program fetch timing wrong");
    push_sp_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_PUSH) |-> ##2 (dmem_out.we &&
        dmem_out.addr == $past(sp_out, 2) && sp_out == dmem_out.addr - 16'h0001))
        else $error("push wrong");
    io_one_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_OUT) |=> (io_we_out && done_out))
        else $error("port write not single cycle");
    kick_one_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_KICK) |=> (kick_out && !busy_out))
        else $error("watchdog kick not single cycle");
    io_map_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_in && !busy_out && cmd_in.op == DTX_OP_LOAD_IO) |-> ##1
        (dmem_out.re && dmem_out.addr == {10'h000, $past(cmd_in.port)} + 16'h0020))
        else $error("io data address offset wrong");
    ptr_mirror_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ($past(cmd_in.ptr) == DTX_PTR_Z) |-> (ptr_val == $past(s_r.z)))
        else $error("pointer bank and mirror differ");
    cover_pop_c: cover property (@(posedge clk_in) dmem_out.re ##1 rf_we_out);
    cover_pmem_c: cover property (@(posedge clk_in) pmem_re_out);
    cover_sleep_c: cover property (@(posedge clk_in) sleep_out);
    cover_brk_c: cover property (@(posedge clk_in) brk_out);
endmodule

/* File: sim/dtx_mem_model.sv */
// Behavioural data memory, program memory and I/O space facing the execution unit.
module dtx_mem_model
    import dtx_pkg::*;
(
    input wire logic clk_in,
    input wire dtx_bus_t dmem_in,
    input wire logic pmem_re_in,
    input wire logic [15:0] pmem_addr_in,
    input wire logic io_we_in,
    input wire logic io_re_in,
    input wire logic [5:0] io_addr_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] dmem_rdata_out,
    output logic [7:0] pmem_rdata_out,
    output logic [7:0] io_rdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] dm_r [256];
    logic [7:0] pm_r [256];
    logic [7:0] io_r [64];
    logic [7:0] dh_r, ph_r, ih_r;
    logic dv_r, pv_r, iv_r;
    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            dm_r[i] = 8'(i) ^ 8'h3c;
            pm_r[i] = ~8'(i);
            if (i < 64)
                io_r[i] = 8'(i) + 8'h01;
        end
        {dv_r, pv_r, iv_r} = 3'h0;
        {dh_r, ph_r, ih_r} = 24'h0;
    end
    // Read data is valid in the strobe cycle and the one after it only.
    always @(posedge clk_in)
    begin
        if (dmem_in.we)
            dm_r[dmem_in.addr[7:0]] <= dmem_in.wdata;
        if (io_we_in)
            io_r[io_addr_in] <= io_wdata_in;
        dv_r <= dmem_in.re;
        pv_r <= pmem_re_in;
        iv_r <= io_re_in;
        if (dmem_in.re)
            dh_r <= dm_r[dmem_in.addr[7:0]];
        if (pmem_re_in)
            ph_r <= pm_r[pmem_addr_in[7:0]];
        if (io_re_in)
            ih_r <= io_r[io_addr_in];
    end
    // Outside that window the lines show inverted data so a late sample is caught.
    assign dmem_rdata_out = dmem_in.re ? dm_r[dmem_in.addr[7:0]] : (dv_r ? dh_r : ~dh_r);
    assign pmem_rdata_out = pmem_re_in ? pm_r[pmem_addr_in[7:0]] : (pv_r ? ph_r : ~ph_r);
    assign io_rdata_out = io_re_in ? io_r[io_addr_in] : (iv_r ? ih_r : ~ih_r);
endmodule

/* File: sim/test_cpu_data_transfer_exec.sv */
// Self-checking bench for the data-transfer execution unit.
module test_cpu_data_transfer_exec;
    import dtx_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        dtx_cmd_t c;
        logic [2:0] cy;
        logic [8:0] k;
        logic [15:0] a;
        logic [7:0] d;
    } dtx_row_t;
    logic clk_in, rst_n_in, start_in;
    dtx_cmd_t cmd_in;
    logic [7:0] rf_rdata, dm_rd, pm_rd, io_rd, io_wdata, rf_wdata;
    logic [4:0] rf_ridx, rf_widx;
    logic busy_out, done_out, pmem_re, io_we, io_re, rf_we, sleep_out, kick_out, brk_out;
    dtx_bus_t dmem;
    logic [15:0] pmem_addr, z_out, sp_out, ev_a, z_e, sp_e;
    logic [5:0] io_addr;
    logic [8:0] ev_k;
    logic [7:0] ev_d;
    logic [4:0] ev_i;
    int n_mismatch, tests_run, n;
    dtx_row_t rows[$];
    dtx_exec dtx_exec_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
        .cmd_in(cmd_in), .rf_rdata_in(rf_rdata), .dmem_rdata_in(dm_rd),
        .pmem_rdata_in(pm_rd), .io_rdata_in(io_rd), .rf_ridx_out(rf_ridx),
        .busy_out(busy_out), .done_out(done_out), .dmem_out(dmem), .pmem_re_out(pmem_re),
        .pmem_addr_out(pmem_addr), .io_we_out(io_we), .io_re_out(io_re),
        .io_addr_out(io_addr), .io_wdata_out(io_wdata), .rf_we_out(rf_we),
        .rf_widx_out(rf_widx), .rf_wdata_out(rf_wdata), .z_out(z_out), .sp_out(sp_out),
        .sleep_out(sleep_out), .kick_out(kick_out), .brk_out(brk_out));
    dtx_mem_model dtx_mem_model_i (.clk_in(clk_in), .dmem_in(dmem), .pmem_re_in(pmem_re),
        .pmem_addr_in(pmem_addr), .io_we_in(io_we), .io_re_in(io_re), .io_addr_in(io_addr),
        .io_wdata_in(io_wdata), .dmem_rdata_out(dm_rd), .pmem_rdata_out(pm_rd),
        .io_rdata_out(io_rd));
    // Register file stand-in: each register holds its index xor a5.
    assign rf_rdata = {3'h0, rf_ridx} ^ 8'ha5;
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Records every strobe seen since the last issue.
    always @(posedge clk_in)
    begin
        if (dmem.we) begin ev_k[8] <= 1'b1; ev_a <= dmem.addr; ev_d <= dmem.wdata; end
        if (dmem.re) begin ev_k[7] <= 1'b1; ev_a <= dmem.addr; end
        if (pmem_re) begin ev_k[6] <= 1'b1; ev_a <= pmem_addr; end
        if (io_we) begin ev_k[5] <= 1'b1; ev_a <= {10'h0, io_addr}; ev_d <= io_wdata; end
        if (io_re) begin ev_k[4] <= 1'b1; ev_a <= {10'h0, io_addr}; end
        if (rf_we) begin ev_k[3] <= 1'b1; ev_d <= rf_wdata; ev_i <= rf_widx; end
        if (sleep_out) ev_k[2] <= 1'b1;
        if (kick_out) ev_k[1] <= 1'b1;
        if (brk_out) ev_k[0] <= 1'b1;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic issue(input dtx_cmd_t c, input logic hold);
        @(posedge clk_in);
        #1 start_in = 1'b1;
        cmd_in = c;
        @(posedge clk_in);
        #1 start_in = hold;
        {ev_k, ev_a, ev_d, ev_i} = '0;
    endtask
    task automatic wait_done();
        n = 1;
        while (done_out !== 1'b1 && n < 10)
        begin
            @(posedge clk_in);
            #1 n++;
        end
        if (n >= 10)
        begin
            $display("BAD %0t no completion", $time);
            n_mismatch++;
            close_out();
        end
    endtask
    function automatic void row(dtx_op_t o, dtx_ptr_t p, logic [4:0] r, logic [15:0] a,
        logic u, logic [2:0] cy, logic [8:0] k, logic [15:0] ea, logic [7:0] d);
        rows.push_back('{'{o, p, r, a, a[5:0], a[5:0], u}, cy, k, ea, d});
    endfunction
    function automatic dtx_cmd_t mk(dtx_op_t o, logic [4:0] r, logic [15:0] a);
        return '{o, DTX_PTR_Z, r, a, 6'h00, 6'h00, 1'b0};
    endfunction
    initial
    begin
        {n_mismatch, tests_run, n} = '0;
        {ev_k, ev_a, ev_d, ev_i} = '0;
        start_in = 1'b0;
        cmd_in = '0;
        rst_n_in = 1'b0;
        row(DTX_OP_WR_PTR_INC, DTX_PTR_X, 5'h3, 16'h0, 1'b0, 3'h2, 9'h100, 16'h0, 8'ha6);
        row(DTX_OP_WR_PTR_INC, DTX_PTR_X, 5'h4, 16'h0, 1'b0, 3'h2, 9'h100, 16'h1, 8'ha1);
        row(DTX_OP_WR_PTR_DEC, DTX_PTR_Y, 5'h5, 16'h0, 1'b0, 3'h2, 9'h100, 16'hffff,
            8'ha0);
        row(DTX_OP_WR_OFS, DTX_PTR_Y, 5'h6, 16'h3f, 1'b0, 3'h2, 9'h100, 16'h3e, 8'ha3);
        row(DTX_OP_WR_PTR, DTX_PTR_Z, 5'h7, 16'h0, 1'b0, 3'h2, 9'h100, 16'h0, 8'ha2);
        row(DTX_OP_WR_PTR_INC, DTX_PTR_Z, 5'h11, 16'h0, 1'b0, 3'h2, 9'h100, 16'h0, 8'hb4);
        row(DTX_OP_WR_PTR_DEC, DTX_PTR_Z, 5'h12, 16'h0, 1'b0, 3'h2, 9'h100, 16'h0, 8'hb7);
        row(DTX_OP_WR_ABS, DTX_PTR_X, 5'h8, 16'h40, 1'b0, 3'h2, 9'h100, 16'h40, 8'had);
        row(DTX_OP_LOAD_ABS, DTX_PTR_X, 5'h9, 16'h40, 1'b0, 3'h2, 9'h088, 16'h40, 8'had);
        row(DTX_OP_LOAD_IO, DTX_PTR_X, 5'ha, 16'h5, 1'b0, 3'h2, 9'h088, 16'h25, 8'h19);
        row(DTX_OP_PMEM_INC, DTX_PTR_Z, 5'hb, 16'h0, 1'b0, 3'h3, 9'h048, 16'h0, 8'hff);
        row(DTX_OP_PMEM, DTX_PTR_Z, 5'hc, 16'h0, 1'b1, 3'h3, 9'h048, 16'h1, 8'hfe);
        row(DTX_OP_PUSH, DTX_PTR_X, 5'hd, 16'h0, 1'b0, 3'h2, 9'h100, 16'hdf, 8'ha8);
        row(DTX_OP_POP, DTX_PTR_X, 5'he, 16'h0, 1'b0, 3'h2, 9'h088, 16'hdf, 8'ha8);
        row(DTX_OP_OUT, DTX_PTR_X, 5'hf, 16'h11, 1'b0, 3'h1, 9'h020, 16'h11, 8'haa);
        row(DTX_OP_IN, DTX_PTR_X, 5'h10, 16'h11, 1'b0, 3'h1, 9'h018, 16'h11, 8'haa);
        row(DTX_OP_SLEEP, DTX_PTR_X, 5'h0, 16'h0, 1'b0, 3'h1, 9'h004, 16'h0, 8'h0);
        row(DTX_OP_KICK, DTX_PTR_X, 5'h0, 16'h0, 1'b0, 3'h1, 9'h002, 16'h0, 8'h0);
        row(DTX_OP_BREAK, DTX_PTR_X, 5'h0, 16'h0, 1'b0, 3'h1, 9'h001, 16'h0, 8'h0);
        row(DTX_OP_NOP, DTX_PTR_X, 5'h0, 16'h0, 1'b0, 3'h1, 9'h000, 16'h0, 8'h0);
        repeat (6) @(posedge clk_in);
        #1 chk(sp_out, 16'h00df, "stack pointer at reset");
        chk({busy_out, done_out, dmem.we, dmem.re, pmem_re, io_we, rf_we, kick_out}, '0, "idle");
        rst_n_in = 1'b1;
        z_e = 16'h0000;
        sp_e = 16'h00df;
        foreach (rows[i])
        begin
            issue(rows[i].c, 1'b0);
            wait_done();
            chk(16'(n), {13'h0, rows[i].cy}, "cycle count");
            repeat (2) @(posedge clk_in);
            #1 chk({7'h0, ev_k}, {7'h0, rows[i].k}, "strobes");
            chk(ev_a, rows[i].a, "address");
            chk({8'h0, ev_d}, {8'h0, rows[i].d}, "data");
            if (rows[i].k[3])
                chk({11'h0, ev_i}, {11'h0, rows[i].c.use_r0 ? 5'h00 : rows[i].c.reg_idx},
                    "index");
            if (rows[i].c.op == DTX_OP_PMEM_INC ||
                (rows[i].c.op == DTX_OP_WR_PTR_INC && rows[i].c.ptr == DTX_PTR_Z))
                z_e++;
            if (rows[i].c.op == DTX_OP_WR_PTR_DEC && rows[i].c.ptr == DTX_PTR_Z)
                z_e--;
            if (rows[i].c.op == DTX_OP_PUSH)
                sp_e--;
            if (rows[i].c.op == DTX_OP_POP)
                sp_e++;
            chk(z_out, z_e, "pointer Z");
            chk(sp_out, sp_e, "stack pointer");
        end
        // A start held during a busy store is ignored, then taken in the done cycle.
        issue(mk(DTX_OP_WR_ABS, 5'h01, 16'h0050), 1'b1);
        cmd_in = mk(DTX_OP_KICK, 5'h00, 16'h0000);
        wait_done();
        chk(16'(n), 16'h0002, "busy store cycles");
        @(posedge clk_in);
        #1 start_in = 1'b0;
        chk({7'h0, ev_k}, 16'h0100, "refused start");
        chk(ev_a, 16'h0050, "absolute address");
        chk({15'h0, kick_out}, 16'h0001, "back-to-back kick");
        // Reset in the middle of a program fetch clears the unit and Z, and sets the stack pointer to 0x00df.
        issue(mk(DTX_OP_PMEM_INC, 5'h02, 16'h0000), 1'b0);
        rst_n_in = 1'b0;
        #1 chk({15'h0, busy_out}, 16'h0000, "busy after reset");
        chk(z_out, 16'h0000, "pointer after reset");
        chk(sp_out, 16'h00df, "stack pointer after reset");
        repeat (2) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        issue(mk(DTX_OP_NOP, 5'h00, 16'h0000), 1'b0);
        wait_done();
        chk(16'(n), 16'h0001, "nop after reset");
        close_out();
    end
endmodule
